// ---- rtl/ectc_top.sv ----
// Extended raster timing control: registers, overflow merge, TV enable, retrace point, sync select
// How it works
// - Overflow register bit 7 selects interlaced raster; clear means progressive unless end-high bit 7 is set in a double-scan mode.
// - Interlaced retrace starts at the programmed character position in odd fields, at line start in even fields; ignored when progressive.
// - Overflow bits 3..0 supply bit 10 of four vertical timing values.
// - TV vertical enable rises when line count equals the start value.
// - TV vertical enable falls at the 11-bit end value from two registers.
// - End-high bit 7 turns on interlaced timing for double-scan modes.
// - End-high bits 6:5 supply horizontal blank end bits 7:6.
// - End-high bits 4:3 supply vertical blank end bits 9:8.
// - A 10-bit expansion constant is held across low and high registers.
// - Text modes repeat the last character row low-three-bits times.
// - Sync select clear gives NOR of syncs, set gives equaliser output.
// - Equalisation pulses last the 6-bit width times four clocks.
// - All registers reset to zero and are readable and writable.
// - Serration pulses last the 6-bit width times four clocks.
`timescale 1ns/100ps
module ectc_top import ectc_pkg::*; (
    // Clock and reset
    input  wire logic        CLOCK,
    input  wire logic        RST_N,
    // Indexed controller data port
    input  wire logic [7:0]  CRTC_INDEX,
    input  wire logic [7:0]  CRTC_WDATA,
    input  wire logic        CRTC_WR,
    input  wire logic        CRTC_RD,
    output logic      [7:0]  CRTC_RDATA,
    // Low parts from the standard timing registers
    input  wire logic [9:0]  VTOTAL_LO,
    input  wire logic [9:0]  VDEND_LO,
    input  wire logic [9:0]  VBSTART_LO,
    input  wire logic [9:0]  VRSTART_LO,
    input  wire logic [5:0]  HBEND_LO,
    input  wire logic [7:0]  VBEND_LO,
    // Raster state from the timing counters
    input  wire logic [10:0] VCOUNT,
    input  wire logic [7:0]  HCHAR,
    input  wire logic        LINE_START,
    input  wire logic        HALF_LINE,
    input  wire logic        HSYNC,
    input  wire logic        VSYNC,
    input  wire logic        DISPLAY_LINE,
    input  wire logic        DOUBLE_SCAN,
    input  wire logic        TEXT_MODE,
    input  wire logic        LAST_ROW_END,
    // Widened timing values
    output logic      [10:0] VTOTAL,
    output logic      [10:0] VDEND,
    output logic      [10:0] VBSTART,
    output logic      [10:0] VRSTART,
    output logic      [7:0]  HBEND,
    output logic      [9:0]  VBEND,
    // Raster control results
    output logic             INTERLACE_ON,
    output logic             ODD_FIELD,
    output logic             VRETRACE_GO,
    output logic             TV_VDE,
    output logic             COMPOSITE_SYNC,
    output logic      [9:0]  VEXPAND_CONSTANT,
    output logic             REPEAT_LINE
);

    logic [7:0]  regs [REG_COUNT];
    logic [7:0]  rd_val;
    logic [10:0] vrs;
    logic [10:0] tv_end;
    logic [10:0] pre_from;
    logic [9:0]  vconst;
    logic        frame_start;
    logic        next_interlace;
    logic        next_retrace;
    ectc_sub_if  sub ();

    // Register storage; one write port per slot, reserved bits masked off
    for (genvar g = 0; g < REG_COUNT; g++) begin : g_reg
        always_ff @(posedge CLOCK or negedge RST_N) begin
            if (!RST_N) regs[g] <= REG_RESET;
            else if (CRTC_WR && CRTC_INDEX == REG_INDEX[g]) regs[g] <= CRTC_WDATA & REG_MASK[g];
        end
    end

    // Read mux; indices owned elsewhere read as zero
    always_comb begin
        rd_val = 8'h00;
        for (int i = 0; i < REG_COUNT; i++) begin
            if (CRTC_INDEX == REG_INDEX[i]) rd_val = regs[i];
        end
    end

    // Read data held until the next read strobe
    always_ff @(posedge CLOCK or negedge RST_N) begin
        if (!RST_N) CRTC_RDATA <= 8'h00;
        else if (CRTC_RD) CRTC_RDATA <= rd_val;
    end

    // Derived values used by several processes
    assign vrs         = {regs[SLOT_OVF][OVF_VRS], VRSTART_LO};
    assign tv_end      = {regs[SLOT_TVEH][TVEH_END_HI:0], regs[SLOT_TVEL]};
    assign vconst      = {regs[SLOT_DDAH][DDAH_HI:0], regs[SLOT_DDAL]};
    assign frame_start = LINE_START && VCOUNT == '0;
    assign pre_from    = vrs - EQ_LINES;
    // Double-scan interlace only matters while a double-scan mode runs
    assign next_interlace = regs[SLOT_OVF][OVF_IME] || (regs[SLOT_TVEH][TVEH_ITE] && DOUBLE_SCAN);

    // Widened vertical and blank values, registered so the counters see clean edges
    always_ff @(posedge CLOCK or negedge RST_N) begin
        if (!RST_N) begin
            VTOTAL  <= '0;
            VDEND   <= '0;
            VBSTART <= '0;
            VRSTART <= '0;
        end else begin
            VTOTAL  <= {regs[SLOT_OVF][OVF_VT], VTOTAL_LO};
            VDEND   <= {regs[SLOT_OVF][OVF_VDE], VDEND_LO};
            VBSTART <= {regs[SLOT_OVF][OVF_VBS], VBSTART_LO};
            VRSTART <= vrs;
        end
    end

    // Blank end upper bits carried by the TV end-high register
    always_ff @(posedge CLOCK or negedge RST_N) begin
        if (!RST_N) begin
            HBEND <= '0;
            VBEND <= '0;
        end else begin
            HBEND <= {regs[SLOT_TVEH][TVEH_HBE_HI:TVEH_HBE_LO], HBEND_LO};
            VBEND <= {regs[SLOT_TVEH][TVEH_VBE_HI:TVEH_VBE_LO], VBEND_LO};
        end
    end

    // Expansion constant published for the fetch logic
    always_ff @(posedge CLOCK or negedge RST_N) begin
        if (!RST_N) VEXPAND_CONSTANT <= '0;
        else VEXPAND_CONSTANT <= vconst;
    end

    // Interlace selection
    always_ff @(posedge CLOCK or negedge RST_N) begin
        if (!RST_N) INTERLACE_ON <= 1'b0;
        else INTERLACE_ON <= next_interlace;
    end

    // Field flips once per frame while interlaced, sits even otherwise
    always_ff @(posedge CLOCK or negedge RST_N) begin
        if (!RST_N) ODD_FIELD <= 1'b0;
        else if (!INTERLACE_ON) ODD_FIELD <= 1'b0;
        else if (frame_start) ODD_FIELD <= !ODD_FIELD;
    end

    // Odd field starts retrace mid-line at the programmed character, giving the half-line offset
    always_comb begin
        next_retrace = 1'b0;
        if (VCOUNT == vrs) begin
            if (INTERLACE_ON && ODD_FIELD) next_retrace = HCHAR == regs[SLOT_IRET];
            else next_retrace = LINE_START;
        end
    end

    always_ff @(posedge CLOCK or negedge RST_N) begin
        if (!RST_N) VRETRACE_GO <= 1'b0;
        else VRETRACE_GO <= next_retrace;
    end

    // TV display window; the end match wins if both values coincide
    always_ff @(posedge CLOCK or negedge RST_N) begin
        if (!RST_N) TV_VDE <= 1'b0;
        else if (VCOUNT == tv_end) TV_VDE <= 1'b0;
        else if (VCOUNT == {3'h0, regs[SLOT_TVS]}) TV_VDE <= 1'b1;
    end

    // Feed the engines from the same clock, so no synchronisers are needed
    assign sub.line_start   = LINE_START;
    assign sub.half_line    = HALF_LINE;
    assign sub.hsync        = HSYNC;
    assign sub.vsync        = VSYNC;
    assign sub.pre_eq       = vrs >= EQ_LINES && VCOUNT >= pre_from && VCOUNT < vrs;
    assign sub.eq_width     = regs[SLOT_EQ][WIDTH_HI:0];
    assign sub.serr_width   = regs[SLOT_SERR][WIDTH_HI:0];
    assign sub.frame_start  = frame_start;
    assign sub.disp_line    = DISPLAY_LINE;
    assign sub.text_mode    = TEXT_MODE;
    assign sub.last_row_end = LAST_ROW_END;
    assign sub.vconst       = vconst;
    assign sub.src_lines    = VDEND_LO;

    ectc_sync_eq u_sync_eq (
        .clock (CLOCK),
        .rst_n (RST_N),
        .sb    (sub.eq)
    );

    ectc_vexp_dda u_vexp_dda (
        .clock (CLOCK),
        .rst_n (RST_N),
        .sb    (sub.dda)
    );

    // Composite sync source; active-high syncs give active-low composite
    always_ff @(posedge CLOCK or negedge RST_N) begin
        if (!RST_N) COMPOSITE_SYNC <= 1'b1;
        else if (regs[SLOT_EQ][EQ_CSS]) COMPOSITE_SYNC <= sub.composite_sync_eq;
        else COMPOSITE_SYNC <= !(HSYNC || VSYNC);
    end

    // Repeat flag comes from a flop inside the expansion engine
    assign REPEAT_LINE = sub.repeat_line;

    default clocking cb @(posedge CLOCK); endclocking
    default disable iff (!RST_N);

    a_reg_readback: assert property (
        CRTC_WR && CRTC_INDEX == IDX_TVS ##1 !CRTC_WR ##1 CRTC_RD && !CRTC_WR && CRTC_INDEX == IDX_TVS
        |=> CRTC_RDATA == $past(CRTC_WDATA, 3)) else $error("register readback mismatch");
    a_ovf_vtotal: assert property (
        CRTC_WR && CRTC_INDEX == IDX_OVF ##1 !CRTC_WR
        |=> VTOTAL[10] == $past(CRTC_WDATA[OVF_VT], 2) && VRSTART[10] == $past(CRTC_WDATA[OVF_VRS], 2))
        else $error("vertical bit 10 not taken from overflow");
    a_ovf_interlace: assert property (
        CRTC_WR && CRTC_INDEX == IDX_OVF && !DOUBLE_SCAN ##1 !CRTC_WR && !DOUBLE_SCAN
        |=> INTERLACE_ON == $past(CRTC_WDATA[OVF_IME], 2)) else $error("interlace enable not followed");
    a_dscan_interlace: assert property (
        regs[SLOT_TVEH][TVEH_ITE] && DOUBLE_SCAN |=> INTERLACE_ON)
        else $error("double-scan interlace missing");
    a_hblank_upper: assert property (
        CRTC_WR && CRTC_INDEX == IDX_TVEH ##1 !CRTC_WR
        |=> HBEND[7:6] == $past(CRTC_WDATA[TVEH_HBE_HI:TVEH_HBE_LO], 2))
        else $error("hblank end upper bits wrong");
    a_vblank_upper: assert property (
        CRTC_WR && CRTC_INDEX == IDX_TVEH ##1 !CRTC_WR
        |=> VBEND[9:8] == $past(CRTC_WDATA[TVEH_VBE_HI:TVEH_VBE_LO], 2))
        else $error("vblank end upper bits wrong");
    a_dda_constant: assert property (
        CRTC_WR && CRTC_INDEX == IDX_DDAH ##1 !CRTC_WR
        |=> VEXPAND_CONSTANT[9:8] == $past(CRTC_WDATA[DDAH_HI:0], 2)
        && (CRTC_RDATA[7:2] == 6'h00 || !($past(CRTC_RD) && $past(CRTC_INDEX) == IDX_DDAH)))
        else $error("expansion constant high bits wrong");
    a_tv_vde_on: assert property (
        VCOUNT == {3'h0, regs[SLOT_TVS]} && VCOUNT != tv_end |=> TV_VDE)
        else $error("TV enable did not rise");
    a_tv_vde_off: assert property (
        VCOUNT == tv_end |=> !TV_VDE ##1 !TV_VDE || $past(VCOUNT) != tv_end)
        else $error("TV enable did not fall");
    a_composite_sync_nor: assert property (
        !regs[SLOT_EQ][EQ_CSS] |=> COMPOSITE_SYNC == !($past(HSYNC) || $past(VSYNC)))
        else $error("composite sync not NOR of syncs");
    a_retrace_point: assert property (
        INTERLACE_ON && ODD_FIELD && VCOUNT == vrs |=> VRETRACE_GO == ($past(HCHAR) == $past(regs[SLOT_IRET])))
        else $error("interlaced retrace at wrong position");
    a_retrace_prog: assert property (
        !INTERLACE_ON && VCOUNT == vrs && LINE_START |=> VRETRACE_GO)
        else $error("progressive retrace missing");

    c_eq_mode: cover property (regs[SLOT_EQ][EQ_CSS] && VSYNC ##1 !COMPOSITE_SYNC);
    c_ilace_retrace: cover property (INTERLACE_ON && ODD_FIELD ##0 next_retrace ##1 VRETRACE_GO);
    c_tv_window: cover property ($rose(TV_VDE));
    c_line_repeat: cover property ($rose(REPEAT_LINE));

endmodule : ectc_top

// ---- include/ectc_pkg.sv ----
// Package: indices, field positions, reset values and state codes for the extended timing block
package ectc_pkg;

    // Register indices on the indexed controller data port
    localparam logic [7:0] IDX_OVF  = 8'h30;
    localparam logic [7:0] IDX_IRET = 8'h31;
    localparam logic [7:0] IDX_TVS  = 8'h32;
    localparam logic [7:0] IDX_TVEH = 8'h33;
    localparam logic [7:0] IDX_TVEL = 8'h34;
    localparam logic [7:0] IDX_DDAL = 8'h35;
    localparam logic [7:0] IDX_DDAH = 8'h36;
    localparam logic [7:0] IDX_EQ   = 8'h38;
    localparam logic [7:0] IDX_SERR = 8'h39;

    // Storage slots and per-slot write masks (reserved bits read as zero)
    localparam int SLOT_OVF  = 0;
    localparam int SLOT_IRET = 1;
    localparam int SLOT_TVS  = 2;
    localparam int SLOT_TVEH = 3;
    localparam int SLOT_TVEL = 4;
    localparam int SLOT_DDAL = 5;
    localparam int SLOT_DDAH = 6;
    localparam int SLOT_EQ   = 7;
    localparam int SLOT_SERR = 8;
    localparam int REG_COUNT = 9;
    localparam logic [7:0] REG_INDEX [REG_COUNT] = '{IDX_OVF, IDX_IRET, IDX_TVS, IDX_TVEH,
        IDX_TVEL, IDX_DDAL, IDX_DDAH, IDX_EQ, IDX_SERR};
    localparam logic [7:0] REG_MASK [REG_COUNT] = '{8'hff, 8'hff, 8'hff, 8'hff,
        8'hff, 8'hff, 8'h03, 8'hbf, 8'h3f};
    localparam logic [7:0] REG_RESET = 8'h00;

    // Field positions
    localparam int OVF_IME     = 7;
    localparam int OVF_VT      = 3;
    localparam int OVF_VDE     = 2;
    localparam int OVF_VBS     = 1;
    localparam int OVF_VRS     = 0;
    localparam int TVEH_ITE    = 7;
    localparam int TVEH_HBE_HI = 6;
    localparam int TVEH_HBE_LO = 5;
    localparam int TVEH_VBE_HI = 4;
    localparam int TVEH_VBE_LO = 3;
    localparam int TVEH_END_HI = 2;
    localparam int DDAH_HI     = 1;
    localparam int EQ_CSS      = 7;
    localparam int WIDTH_HI    = 5;
    localparam int TEXT_REP_HI = 2;

    // Pulse widths count in units of four video clocks
    localparam int PULSE_UNIT_BITS = 2;
    localparam int PULSE_CNT_W     = 8;
    // Equalisation lines before and after vertical sync
    localparam logic [10:0] EQ_LINES = 11'h003;

    // Equaliser states
    typedef enum logic [3:0] {
        EQ_IDLE = 4'b0001,
        EQ_PRE  = 4'b0010,
        EQ_SERR = 4'b0100,
        EQ_POST = 4'b1000
    } ectc_eq_e;

endpackage : ectc_pkg

// ---- include/ectc_sub_if.sv ----
// Interface: raster events and results between the top and its sync and expansion engines
`timescale 1ns/100ps
interface ectc_sub_if;
    logic       line_start;
    logic       half_line;
    logic       hsync;
    logic       vsync;
    logic       pre_eq;
    logic [5:0] eq_width;
    logic [5:0] serr_width;
    logic       composite_sync_eq;
    logic       frame_start;
    logic       disp_line;
    logic       text_mode;
    logic       last_row_end;
    logic [9:0] vconst;
    logic [9:0] src_lines;
    logic       repeat_line;

    modport top (output line_start, half_line, hsync, vsync, pre_eq, eq_width, serr_width,
                 frame_start, disp_line, text_mode, last_row_end, vconst, src_lines,
                 input composite_sync_eq, repeat_line);
    modport eq  (input line_start, half_line, hsync, vsync, pre_eq, eq_width, serr_width,
                 output composite_sync_eq);
    modport dda (input line_start, frame_start, disp_line, text_mode, last_row_end, vconst,
                 src_lines, output repeat_line);
endinterface : ectc_sub_if

// ---- rtl/ectc_sync_eq.sv ----
// Equaliser state machine that builds composite sync for a TV encoder
`timescale 1ns/100ps
module ectc_sync_eq import ectc_pkg::*; (
    // Clock and reset
    input wire logic clock,
    input wire logic rst_n,
    // Raster events and widths
    ectc_sub_if.eq   sb
);

    ectc_eq_e               state;
    logic [10:0]            lines;
    logic [PULSE_CNT_W-1:0] cnt;
    logic [PULSE_CNT_W-1:0] load;
    logic                   ev;
    logic                   busy;

    assign ev   = sb.line_start | sb.half_line;
    assign busy = cnt != '0;

    // Pre-equalise, serrate through vsync, then post-equalise
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            state <= EQ_IDLE;
        end else begin
            case (state)
                EQ_IDLE: begin
                    if (sb.vsync) state <= EQ_SERR;
                    else if (sb.pre_eq) state <= EQ_PRE;
                end
                EQ_PRE: begin
                    if (sb.vsync) state <= EQ_SERR;
                    else if (!sb.pre_eq) state <= EQ_IDLE;
                end
                EQ_SERR: begin
                    if (!sb.vsync) state <= EQ_POST;
                end
                EQ_POST: begin
                    if (sb.vsync) state <= EQ_SERR;
                    else if (sb.line_start && lines == EQ_LINES - 11'h001) state <= EQ_IDLE;
                end
                default: state <= EQ_IDLE;
            endcase
        end
    end

    // Lines spent after vsync
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) lines <= '0;
        else if (state != EQ_POST) lines <= '0;
        else if (sb.line_start) lines <= lines + 11'h001;
    end

    // Width loaded at each half-line event
    always_comb begin
        case (state)
            EQ_PRE, EQ_POST: load = {sb.eq_width, {PULSE_UNIT_BITS{1'b0}}};
            EQ_SERR:         load = {sb.serr_width, {PULSE_UNIT_BITS{1'b0}}};
            default:         load = '0;
        endcase
    end

    // Pulse timer; a width of zero gives no pulse at all
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) cnt <= '0;
        else if (ev) cnt <= load;
        else if (busy) cnt <= cnt - 8'h01;
    end

    // Low-going equalisers, high-going serration notches inside broad vsync
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            sb.composite_sync_eq <= 1'b1;
        end else begin
            case (state)
                EQ_IDLE:         sb.composite_sync_eq <= !sb.hsync;
                EQ_PRE, EQ_POST: sb.composite_sync_eq <= !busy;
                EQ_SERR:         sb.composite_sync_eq <= busy;
                default:         sb.composite_sync_eq <= 1'b1;
            endcase
        end
    end

    // Helper: measured pulse length against the loaded width
    logic [PULSE_CNT_W-1:0] run;
    logic [PULSE_CNT_W-1:0] want;
    logic                   was_serr;
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            run <= '0;
            want <= '0;
            was_serr <= 1'b0;
        end else if (ev && state != EQ_IDLE) begin
            run <= '0;
            want <= load;
            was_serr <= state == EQ_SERR;
        end else if (busy) begin
            run <= run + 8'h01;
        end
    end

    a_eq_pulse_len: assert property (@(posedge clock) disable iff (!rst_n)
        $fell(busy) && !was_serr |-> run == want) else $error("equaliser pulse width wrong");
    a_serr_pulse_len: assert property (@(posedge clock) disable iff (!rst_n)
        $fell(busy) && was_serr |-> run == want) else $error("serration pulse width wrong");
    a_serr_on_vsync: assert property (@(posedge clock) disable iff (!rst_n)
        state == EQ_PRE && sb.vsync |=> state == EQ_SERR) else $error("vsync did not start serration");

endmodule : ectc_sync_eq

// ---- rtl/ectc_vexp_dda.sv ----
// Vertical expansion engine: line repeat for graphics and text modes
`timescale 1ns/100ps
module ectc_vexp_dda import ectc_pkg::*; (
    // Clock and reset
    input wire logic clock,
    input wire logic rst_n,
    // Raster events and constant
    ectc_sub_if.dda  sb
);

    logic [10:0] acc;
    logic [10:0] sum;
    logic [10:0] dest;
    logic [2:0]  rcnt;
    logic        expand;
    logic        step;

    assign sum    = acc + {1'b0, sb.src_lines};
    assign dest   = {1'b0, sb.vconst};
    assign expand = sb.vconst != '0;
    assign step   = sb.line_start && sb.disp_line && !sb.frame_start && !sb.text_mode && expand;

    // Accumulator advances by the source size each output line
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) acc <= '0;
        else if (sb.frame_start) acc <= '0;
        else if (step) acc <= (sum >= dest) ? sum - dest : sum;
    end

    // Text rows repeated so far this frame
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) rcnt <= '0;
        else if (sb.frame_start) rcnt <= '0;
        else if (sb.text_mode && sb.last_row_end && rcnt < sb.vconst[TEXT_REP_HI:0]) rcnt <= rcnt + 3'h1;
    end

    // Repeat decision; text uses only the low three bits of the constant
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) sb.repeat_line <= 1'b0;
        else if (sb.frame_start) sb.repeat_line <= 1'b0;
        else if (sb.text_mode && sb.last_row_end) sb.repeat_line <= rcnt < sb.vconst[TEXT_REP_HI:0];
        else if (step) sb.repeat_line <= sum < dest;
    end

    a_dda_repeat: assert property (@(posedge clock) disable iff (!rst_n)
        step && sum < dest |=> sb.repeat_line) else $error("source line not repeated");
    a_dda_advance: assert property (@(posedge clock) disable iff (!rst_n)
        step && sum >= dest |=> !sb.repeat_line && acc == $past(sum) - $past(dest))
        else $error("expansion did not advance");
    a_text_repeat_cap: assert property (@(posedge clock) disable iff (!rst_n)
        sb.text_mode && sb.last_row_end && !sb.frame_start && rcnt >= sb.vconst[TEXT_REP_HI:0]
        |=> !sb.repeat_line && $stable(rcnt)) else $error("text row repeated too often");

endmodule : ectc_vexp_dda

// ---- tb/ectc_raster_model.sv ----
// Raster counter model that feeds line and sync events
`timescale 1ns/100ps
module ectc_raster_model (
    // Clock
    input  wire logic        clock,
    // Raster state
    output logic      [10:0] vcount,
    output logic      [7:0]  hchar,
    output logic             line_start,
    output logic             half_line,
    output logic             hsync,
    output logic             vsync
);
    // A 20-line frame of 16 characters keeps the run short
    initial begin
        vcount = 11'h000;
        hchar = 8'h00;
    end
    always @(negedge clock) begin
        hchar <= (hchar == 8'h0f) ? 8'h00 : hchar + 8'h01;
        if (hchar == 8'h0f) begin
            vcount <= (vcount == 11'h013) ? 11'h000 : vcount + 11'h001;
        end
    end
    // Events decoded from the counters; syncs active high
    assign line_start = (hchar == 8'h00);
    assign half_line  = (hchar == 8'h08);
    assign hsync      = (hchar >= 8'h0c);
    assign vsync      = (vcount >= 11'h00a) && (vcount < 11'h00c);
endmodule : ectc_raster_model

// ---- tb/test_extended_crt_timing_control.sv ----
// Self-checking bench for the extended raster timing block
`timescale 1ns/100ps
module test_extended_crt_timing_control;
    import ectc_pkg::*;
    logic        clock = 1'b0;
    logic        rst_n = 1'b0;
    logic        wr = 1'b0;
    logic        rd = 1'b0;
    logic        dscan = 1'b0, disp = 1'b0, text = 1'b0;
    logic [7:0]  idx = 8'h00;
    logic [7:0]  wdata = 8'h00;
    logic [9:0]  lo = 10'h2a5;
    logic [7:0]  rdata, hchar, hblank_end_upper, d;
    logic [10:0] vcount, vt, vde, vbs, vrs;
    logic [9:0]  vblank_end_upper, vconst;
    logic        ls, hl, hs, vs, ilace, tvde, composite_sync, odd, vgo, rep;
    int          num_errors = 0;
    int          n_tests = 0;
    always #12.5 clock = ~clock;
    ectc_raster_model ectc_raster_model_inst (.clock(clock), .vcount(vcount), .hchar(hchar),
        .line_start(ls), .half_line(hl), .hsync(hs), .vsync(vs));
    // Text row end is stood in for by every line start, so repeats show within a few lines
    ectc_top ectc_top_inst (.CLOCK(clock), .RST_N(rst_n), .CRTC_INDEX(idx), .CRTC_WDATA(wdata),
        .CRTC_WR(wr), .CRTC_RD(rd), .CRTC_RDATA(rdata), .VTOTAL_LO(lo), .VDEND_LO(~lo),
        .VBSTART_LO(lo), .VRSTART_LO(~lo), .HBEND_LO(lo[5:0]), .VBEND_LO(lo[7:0]),
        .VCOUNT(vcount), .HCHAR(hchar), .LINE_START(ls), .HALF_LINE(hl), .HSYNC(hs), .VSYNC(vs),
        .DISPLAY_LINE(disp), .DOUBLE_SCAN(dscan), .TEXT_MODE(text), .LAST_ROW_END(text && ls),
        .VTOTAL(vt), .VDEND(vde), .VBSTART(vbs), .VRSTART(vrs), .HBEND(hblank_end_upper), .VBEND(vblank_end_upper),
        .INTERLACE_ON(ilace), .ODD_FIELD(odd), .VRETRACE_GO(vgo), .TV_VDE(tvde),
        .COMPOSITE_SYNC(composite_sync), .VEXPAND_CONSTANT(vconst), .REPEAT_LINE(rep));
    task automatic check(input logic [10:0] seen, input logic [10:0] exp);
        n_tests++;
        if (seen !== exp) begin
            num_errors++;
            $display("Error at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask : check
    // Strobes rise and fall on falling edges so the rising edge sees them settled
    task automatic wr_reg(input logic [7:0] i, input logic [7:0] v);
        @(negedge clock);
        idx = i;
        wdata = v;
        wr = 1'b1;
        @(negedge clock);
        wr = 1'b0;
    endtask : wr_reg
    task automatic rd_reg(input logic [7:0] i);
        @(negedge clock);
        idx = i;
        rd = 1'b1;
        @(negedge clock);
        rd = 1'b0;
        d = rdata;
    endtask : rd_reg
    task automatic t_regs();
        for (int k = 0; k < REG_COUNT; k++) begin
            rd_reg(REG_INDEX[k]);
            check(11'(d), 11'h000);
            wr_reg(REG_INDEX[k], 8'hff);
            rd_reg(REG_INDEX[k]);
            check(11'(d), 11'(REG_MASK[k]));
            wr_reg(REG_INDEX[k], 8'h00);
        end
        wr_reg(8'h37, 8'hff);
        rd_reg(8'h37);
        check(11'(d), 11'h000);
    endtask : t_regs
    task automatic t_overflow();
        for (int k = 0; k < 2; k++) begin
            lo = ~lo;
            wr_reg(IDX_OVF, k ? 8'h05 : 8'h8a);
            @(negedge clock);
            check(vt, {k ? 1'b0 : 1'b1, lo});
            check(vde, {k ? 1'b1 : 1'b0, ~lo});
            check(vbs, {k ? 1'b0 : 1'b1, lo});
            check(vrs, {k ? 1'b1 : 1'b0, ~lo});
            check(11'(ilace), k ? 11'h000 : 11'h001);
        end
    endtask : t_overflow
    task automatic t_tvhigh();
        wr_reg(IDX_TVEH, 8'hd8);
        @(negedge clock);
        check(11'(hblank_end_upper), {3'h0, 2'h2, lo[5:0]});
        check(11'(vblank_end_upper), {1'h0, 2'h3, lo[7:0]});
        check(11'(ilace), 11'h000);
        dscan = 1'b1;
        repeat (2) @(negedge clock);
        check(11'(ilace), 11'h001);
        dscan = 1'b0;
    endtask : t_tvhigh
    task automatic wait_line(input logic [10:0] l);
        for (int k = 0; k < 400 && vcount !== l; k++) @(negedge clock);
    endtask : wait_line
    // Second pass puts the end past the frame so the high end bits must be honoured
    task automatic t_tvde();
        wr_reg(IDX_TVS, 8'h03);
        for (int k = 0; k < 2; k++) begin
            wr_reg(IDX_TVEH, k ? 8'h01 : 8'h00);
            wr_reg(IDX_TVEL, 8'h06);
            wait_line(11'h004);
            check(11'(tvde), 11'h001);
            wait_line(11'h008);
            check(11'(tvde), k ? 11'h001 : 11'h000);
        end
    endtask : t_tvde
    task automatic t_sync_const();
        wr_reg(IDX_EQ, 8'h00);
        repeat (320) begin
            @(negedge clock);
            check(11'(composite_sync), 11'(!(hs || vs)));
        end
        wr_reg(IDX_DDAL, 8'h5a);
        wr_reg(IDX_DDAH, 8'h07);
        @(negedge clock);
        check(11'(vconst), 11'h35a);
    endtask : t_sync_const
    // Retrace on line 13; two frames give one odd and one even field, weighted 2 and 1
    task automatic t_retrace();
        int n = 0;
        lo = 10'h3f2;
        wr_reg(IDX_IRET, 8'h05);
        wr_reg(IDX_OVF, 8'h80);
        repeat (640) begin
            @(negedge clock);
            if (vgo === 1'b1) begin
                n += odd ? 2 : 1;
                check(11'(hchar), odd ? 11'h005 : 11'h000);
            end
        end
        check(11'(n), 11'h003);
        lo = 10'h2a5;
    endtask : t_retrace
    // Graphics: 0x15a source lines into 0x35a; text: constant low bits ask for two repeats
    task automatic t_expand();
        disp = 1'b1;
        for (int m = 0; m < 2; m++) begin
            text = (m == 1);
            wait_line(11'h000);
            for (int l = 1; l < 6; l++) begin
                wait_line(11'(l));
                check(11'(rep), (l == 3 || l == 5 || (m == 1 && l == 4)) ? 11'h000 : 11'h001);
            end
        end
    endtask : t_expand
    task automatic conclude();
        if (num_errors == 0 && n_tests > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask : conclude
    initial begin
        repeat (3) @(posedge clock);
        @(negedge clock);
        rst_n = 1'b1;
        t_regs();
        t_overflow();
        t_tvhigh();
        t_tvde();
        t_retrace();
        t_sync_const();
        t_expand();
        conclude();
    end
    // Watchdog well beyond the few thousand cycles the tests need
    initial begin
        #1000000;
        num_errors++;
        conclude();
    end
endmodule : test_extended_crt_timing_control
